// ==== potsce_pkg.sv ====
// Purpose: Constants and types for the pot serial command engine.
// Assumes: 24-bit frames, command nibble, address nibble, 16 data bits.
// Notes: All timing counts are in clk_in cycles at 10 MHz.
`default_nettype none
// ==========================================================
// Constants and frame layout
package potsce_pkg;
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RESTORE = 4'h1;
  localparam logic [3:0] CMD_STORE_WIPER = 4'h2;
  localparam logic [3:0] CMD_STORE_WORD = 4'h3;
  localparam logic [3:0] CMD_RESTORE_ALL = 4'h8;
  localparam logic [3:0] CMD_READ_WORD = 4'h9;
  localparam logic [3:0] CMD_READ_WIPER = 4'ha;
  localparam logic [3:0] CMD_WRITE_WIPER = 4'hb;
  localparam logic [3:0] CMD_DOUBLE = 4'hc;
  localparam logic [3:0] CMD_INCREMENT = 4'he;
  localparam logic [3:0] SLOT_WIPER = 4'h0;
  localparam logic [3:0] SLOT_OUTPUTS = 4'h1;
  localparam logic [9:0] WIPER_FULL = 10'h3ff;
  localparam logic [9:0] WIPER_RESET = 10'h200;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int NV_WORDS = 16;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } potsce_frame_t;
endpackage
`default_nettype wire

// ==== potsce_engine.sv ====
// Purpose: Serial command engine for a 1024-position nonvolatile potentiometer.
// Assumes: Serial clock, select, data-in, restore and protect pins are async to clk_in.
// Notes: Data is sampled on serial clock rise and shifted out on its fall.
`timescale 1ns/100ps
`default_nettype none
module potsce_engine
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sclk_in,
  input wire logic csn_in,
  input wire logic sdi_in,
  input wire logic restore_strobe_pin_n_in,
  input wire logic write_protect_n_in,
  output logic sdo_out,
  output logic [9:0] wiper_code_out,
  output logic digital_output_one_out,
  output logic digital_output_two_out,
  output logic read_power_out
);
  // ==========================================================
  // Input synchronisers
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic sclk_old_q;
  logic csn_old_q;
  logic strobe_old_q;
  always_ff @(posedge clk_in)
  begin
    meta_q <= {sclk_in, csn_in, sdi_in, restore_strobe_pin_n_in, write_protect_n_in};
    sync_q <= meta_q;
    sclk_old_q <= sync_q[4];
    csn_old_q <= sync_q[3];
    strobe_old_q <= sync_q[1];
  end
  logic sclk_rise;
  logic sclk_fall;
  logic cs_end;
  logic strobe_fall;
  logic sel;
  assign sel = !sync_q[3];
  assign sclk_rise = sel && sync_q[4] && !sclk_old_q;
  assign sclk_fall = sel && !sync_q[4] && sclk_old_q;
  assign cs_end = sync_q[3] && !csn_old_q;
  assign strobe_fall = !sync_q[1] && strobe_old_q;

  // ==========================================================
  // Frame shifter and command execution
  logic [23:0] rx_q;
  logic [23:0] rx_d;
  logic [23:0] tx_q;
  logic [23:0] tx_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [9:0] wiper_q;
  logic [9:0] wiper_d;
  logic [1:0] outs_q;
  logic [1:0] outs_d;
  logic [15:0] nv_q [potsce_pkg::NV_WORDS];
  logic nv_we;
  logic [3:0] nv_addr;
  logic [15:0] nv_wdata;
  logic boot_q;
  logic read_pwr_q;
  logic read_pwr_d;
  potsce_pkg::potsce_frame_t fr;
  assign fr = rx_q;

  function automatic logic [9:0] sat_wiper(input logic [10:0] v);
    sat_wiper = v[10] ? potsce_pkg::WIPER_FULL : v[9:0];
  endfunction

  always_comb
  begin
    rx_d = rx_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    wiper_d = wiper_q;
    outs_d = outs_q;
    read_pwr_d = read_pwr_q;
    nv_we = 1'b0;
    nv_addr = fr.addr;
    nv_wdata = fr.data;
    if (sclk_rise)
    begin
      rx_d = {rx_q[22:0], sync_q[2]};
      cnt_d = (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01;
    end
    if (sclk_fall)
      tx_d = {tx_q[22:0], 1'b0};
    if (boot_q || strobe_fall)
    begin
      wiper_d = nv_q[potsce_pkg::SLOT_WIPER][9:0];
      outs_d = nv_q[potsce_pkg::SLOT_OUTPUTS][1:0];
    end
    else if (cs_end)
    begin
      cnt_d = 6'h00;
      if (cnt_q == 6'(potsce_pkg::FRAME_BITS))
      begin
        tx_d = rx_q;
        read_pwr_d = 1'b0;
        case (fr.cmd)
          potsce_pkg::CMD_WRITE_WIPER: wiper_d = fr.data[9:0];
          potsce_pkg::CMD_INCREMENT: wiper_d = sat_wiper({1'b0, wiper_q} + 11'h001);
          potsce_pkg::CMD_DOUBLE: wiper_d = sat_wiper({wiper_q, 1'b0});
          potsce_pkg::CMD_STORE_WIPER:
          begin
            nv_we = 1'b1;
            nv_addr = potsce_pkg::SLOT_WIPER;
            nv_wdata = {6'h00, wiper_q};
          end
          potsce_pkg::CMD_STORE_WORD: nv_we = 1'b1;
          potsce_pkg::CMD_RESTORE, potsce_pkg::CMD_RESTORE_ALL:
          begin
            wiper_d = nv_q[potsce_pkg::SLOT_WIPER][9:0];
            outs_d = nv_q[potsce_pkg::SLOT_OUTPUTS][1:0];
            read_pwr_d = 1'b1;
          end
          potsce_pkg::CMD_READ_WORD:
          begin
            tx_d = {rx_q[23:16], nv_q[fr.addr]};
            read_pwr_d = 1'b1;
          end
          potsce_pkg::CMD_READ_WIPER: tx_d = {rx_q[23:16], 6'h00, wiper_q};
          default: tx_d = rx_q;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      rx_q <= 24'h000000;
      tx_q <= 24'h000000;
      cnt_q <= 6'h00;
      wiper_q <= potsce_pkg::WIPER_RESET;
      outs_q <= 2'h0;
      boot_q <= 1'b1;
      read_pwr_q <= 1'b0;
    end
    else
    begin
      rx_q <= rx_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      wiper_q <= wiper_d;
      outs_q <= outs_d;
      boot_q <= 1'b0;
      read_pwr_q <= read_pwr_d;
    end
  end

  // ==========================================================
  // Nonvolatile store
  // Reset does not clear the store, since it models cells that survive power loss.
  always_ff @(posedge clk_in)
  begin
    if (nv_we && sync_q[0])
      nv_q[nv_addr] <= nv_wdata;
  end

  assign sdo_out = tx_q[23];
  assign wiper_code_out = wiper_q;
  assign digital_output_one_out = outs_q[0];
  assign digital_output_two_out = outs_q[1];
  assign read_power_out = read_pwr_q;

  // ==========================================================
  // Checks
  // A full frame reaches its command decode in this cycle.
  sequence s_exec;
    cs_end && !boot_q && !strobe_fall && (cnt_q == 6'(potsce_pkg::FRAME_BITS));
  endsequence

  // A select rise closes a frame of the wrong length in this cycle.
  sequence s_cut;
    cs_end && !boot_q && !strobe_fall && (cnt_q != 6'(potsce_pkg::FRAME_BITS));
  endsequence

  property p_wr;
    @(posedge clk_in) disable iff (!rstn_in)
      s_exec ##0 (fr.cmd == potsce_pkg::CMD_WRITE_WIPER) |=> wiper_q == $past(rx_q[9:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("write wiper failed");

  property p_inc;
    @(posedge clk_in) disable iff (!rstn_in)
      s_exec ##0 (fr.cmd == potsce_pkg::CMD_INCREMENT && wiper_q != potsce_pkg::WIPER_FULL)
      |=> wiper_q == $past(wiper_q) + 10'h001;
  endproperty
  a_inc: assert property (p_inc) else $error("increment failed");

  property p_inc_sat;
    @(posedge clk_in) disable iff (!rstn_in)
      s_exec ##0 (fr.cmd == potsce_pkg::CMD_INCREMENT && wiper_q == potsce_pkg::WIPER_FULL)
      |=> wiper_q == potsce_pkg::WIPER_FULL;
  endproperty
  a_inc_sat: assert property (p_inc_sat) else $error("increment wrapped");

  // Any code with its top bit set would overflow, so it pins at full scale.
  property p_double;
    @(posedge clk_in) disable iff (!rstn_in)
      s_exec ##0 (fr.cmd == potsce_pkg::CMD_DOUBLE)
      |=> wiper_q == ($past(wiper_q[9]) ? potsce_pkg::WIPER_FULL : {$past(wiper_q[8:0]), 1'b0});
  endproperty
  a_double: assert property (p_double) else $error("double wrong");

  property p_store_wiper;
    @(posedge clk_in) disable iff (!rstn_in)
      s_exec ##0 (fr.cmd == potsce_pkg::CMD_STORE_WIPER && sync_q[0])
      |=> nv_q[potsce_pkg::SLOT_WIPER] == {6'h00, $past(wiper_q)};
  endproperty
  a_store_wiper: assert property (p_store_wiper) else $error("wiper store lost");

  property p_protect;
    @(posedge clk_in) disable iff (!rstn_in)
      (nv_we && !sync_q[0]) |=> nv_q[$past(nv_addr)] == $past(nv_q[nv_addr]);
  endproperty
  a_protect: assert property (p_protect) else $error("protected word changed");

  property p_strobe;
    @(posedge clk_in) disable iff (!rstn_in)
      strobe_fall |=> (wiper_q == $past(nv_q[potsce_pkg::SLOT_WIPER][9:0]))
        && (outs_q == $past(nv_q[potsce_pkg::SLOT_OUTPUTS][1:0]));
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe restore wrong");

  property p_part;
    @(posedge clk_in) disable iff (!rstn_in)
      s_cut |=> $stable(wiper_q) && $stable(outs_q);
  endproperty
  a_part: assert property (p_part) else $error("partial frame ran");

  // A select rise and a serial clock fall never coincide, so only the shift can touch tx here.
  property p_shift;
    @(posedge clk_in) disable iff (!rstn_in)
      sclk_fall |=> tx_q == {$past(tx_q[22:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift) else $error("data out shift wrong");

  property p_rb;
    @(posedge clk_in) disable iff (!rstn_in)
      s_exec ##0 (fr.cmd == potsce_pkg::CMD_READ_WIPER)
      |=> tx_q == {$past(rx_q[23:16]), 6'h00, $past(wiper_q)};
  endproperty
  a_rb: assert property (p_rb) else $error("readback wrong");

  property p_read_word;
    @(posedge clk_in) disable iff (!rstn_in)
      s_exec ##0 (fr.cmd == potsce_pkg::CMD_READ_WORD)
      |=> (tx_q == {$past(rx_q[23:16]), $past(nv_q[fr.addr])}) && read_pwr_q;
  endproperty
  a_read_word: assert property (p_read_word) else $error("word read wrong");
endmodule
`default_nettype wire

// ==== potsce_host.sv ====
// Purpose: Host model that shifts frames into the engine.
// Assumes: Serial clock half period of four clk_in cycles.
// Notes: Data-in shows the inverse of its last bit between frames.
`timescale 1ns/100ps
`default_nettype none
module potsce_host
(
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic sclk_out,
  output logic csn_out,
  output logic sdi_out
);
  logic [23:0] rx;
  task automatic half();
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  // A short count cuts the frame off early. Clock stands low outside frames.
  task automatic send(input logic [23:0] f, input int n);
    csn_out = 1'b0;
    half();
    for (int i = 23; i > 23 - n; i--)
    begin
      sdi_out = f[i];
      half();
      rx = {rx[22:0], sdo_in};
      sclk_out = 1'b1;
      half();
      sclk_out = 1'b0;
    end
    half();
    csn_out = 1'b1;
    sdi_out = ~sdi_out;
    half();
  endtask
  initial
  begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    sdi_out = 1'b0;
  end
endmodule
`default_nettype wire

// ==== potsce_engine_tb.sv ====
// Purpose: Self-checking bench for the pot serial command engine.
// Assumes: Wiper and outputs settle 8 clk_in cycles after select rises.
// Notes: Unknown store contents are skipped, as power-on leaves them unset.
`timescale 1ns/100ps
`default_nettype none
module potsce_engine_tb;
  logic clk_in, rstn_in, sclk, csn, sdi, sdo, restore_n, wp_n, d1, d2, rdp;
  logic [9:0] wiper;
  logic [23:0] echo;
  int errors, checks_done, seed, wm, e_d, known;
  int nv [16];
  potsce_engine u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk), .csn_in(csn), .sdi_in(sdi),
    .restore_strobe_pin_n_in(restore_n), .write_protect_n_in(wp_n), .sdo_out(sdo), .wiper_code_out(wiper),
    .digital_output_one_out(d1), .digital_output_two_out(d2), .read_power_out(rdp));
  potsce_host u_host (.clk_in(clk_in), .sdo_in(sdo), .sclk_out(sclk), .csn_out(csn), .sdi_out(sdi));
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_in);
    #1;
    check("wiper", 24'(wiper), 24'(wm));
    if (e_d >= 0)
      check("outputs", {22'h0, d2, d1}, 24'(e_d));
  endtask
  // The model runs each command on the full frame and predicts the next echo.
  task automatic run(input logic [23:0] f);
    u_host.send(f, 24);
    if (known)
      check("sdo frame", u_host.rx, echo);
    known = 1;
    echo = f;
    case (f[23:20])
      4'hb: wm = f[9:0];
      4'he: wm = (wm == 1023) ? wm : wm + 1;
      4'hc: wm = (wm * 2 > 1023) ? 1023 : wm * 2;
      4'h2: if (wp_n) nv[0] = wm;
      4'h3: if (wp_n) nv[f[19:16]] = f[15:0];
      4'h1, 4'h8:
      begin
        wm = nv[0];
        e_d = nv[1] & 3;
      end
      4'ha: echo = {f[23:16], 6'h00, 10'(wm)};
      4'h9: echo = {f[23:16], 16'(nv[f[19:16]])};
      default: ;
    endcase
    settle();
  endtask
  initial
  begin
    repeat (100000) @(posedge clk_in);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    {seed, errors, checks_done, known, e_d, echo} = {32'd84, 96'd0, -32'sd1, 24'h0};
    rstn_in = 1'b0;
    restore_n = 1'b1;
    wp_n = 1'b1;
    repeat (12) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    run(24'hb00100);
    run(24'he0abcd);
    run(24'hb003ff);
    run(24'he01234);
    run(24'hb00200);
    run(24'hc00000);
    run(24'ha00000);
    run(24'h000000);
    $display("wiper arithmetic test done");
    run(24'h310003);
    run(24'h200000);
    run(24'hb00005);
    run(24'h100000);
    run(24'h000000);
    run(24'hb00007);
    restore_n = 1'b0;
    wm = nv[0];
    settle();
    restore_n = 1'b1;
    $display("store and restore test done");
    run(24'hb00009);
    run(24'h800000);
    check("read power", 24'(rdp), 24'h1);
    run(24'h000000);
    check("read power", 24'(rdp), 24'h0);
    run(24'hb0000a);
    rstn_in = 1'b0;
    repeat (12) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    known = 0;
    wm = nv[0];
    settle();
    $display("restore command and power-on test done");
    for (int a = 2; a < 16; a++)
      run({4'h3, 4'(a), 16'($random(seed))});
    for (int a = 2; a < 16; a++)
    begin
      run({4'h9, 4'(a), 16'h0});
      check("read power", 24'(rdp), 24'h1);
      run(24'h000000);
      check("read power", 24'(rdp), 24'h0);
    end
    $display("user word test done");
    wp_n = 1'b0;
    run(24'h32ffff);
    run(24'h920000);
    run(24'h000000);
    wp_n = 1'b1;
    u_host.send(24'hb00011, 23);
    known = 0;
    settle();
    $display("protect and partial frame test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
